/* File: snf_frame_buf.v */
// Two-entry frame buffer with valid and ready on both sides
`timescale 1ns/1ps
module snf_frame_buf #(
   parameter W = 10
) (
   // Clock and reset
   input  wire         sys_clk,
   input  wire         arst_n,
   // Filling side
   input  wire [W-1:0] inData,
   input  wire         inValid,
   output wire         inReady,
   // Draining side
   output wire [W-1:0] outData,
   output wire         outValid,
   input  wire         outReady
);

   reg  [W-1:0] head_reg;
   reg  [W-1:0] spare_reg;
   reg          headValid_reg;
   reg          spareValid_reg;
   wire         push;
   wire         pop;

   // Head drives the outputs directly, spare catches a word during a stall
   assign outData  = head_reg;
   assign outValid = headValid_reg;
   assign inReady  = ~spareValid_reg;
   assign push     = inValid & ~spareValid_reg;
   assign pop      = headValid_reg & outReady;

   // Spare full blocks the filler, so a pop with a full spare never meets a push
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         head_reg       <= {W{1'b0}};
         spare_reg      <= {W{1'b0}};
         headValid_reg  <= 1'b0;
         spareValid_reg <= 1'b0;
      end else if (pop && spareValid_reg) begin
         head_reg       <= spare_reg;
         spareValid_reg <= 1'b0;
      end else if (pop) begin
         headValid_reg  <= push;
         if (push) begin
            head_reg <= inData;
         end
      end else if (push && !headValid_reg) begin
         head_reg       <= inData;
         headValid_reg  <= 1'b1;
      end else if (push) begin
         spare_reg      <= inData;
         spareValid_reg <= 1'b1;
      end
   end

endmodule // snf_frame_buf

/* File: snf_map.vh */
// Register map, field positions, reset values and codes of the SENT status nibble formatter
`ifndef SNF_MAP_VH
`define SNF_MAP_VH

// Register indexes; byte address is four times the index
`define SNF_CFG_IDX      8'h1E
`define SNF_CTRL_IDX     8'h20
`define SNF_MSG_IDX      8'h21
`define SNF_STAT_IDX     8'h22
`define SNF_ADDR_W       8

// Configuration word fields
`define SNF_CFG_W        18
`define SNF_CFG_RST      18'h0_0000
`define SNF_SERIAL_LSB   0
`define SNF_STYLE_BIT    2
`define SNF_UPDATE_LSB   5
`define SNF_LEVEL_BIT    8
`define SNF_FIXED_LSB    9

// Control word fields
`define SNF_CTRL_RST     2'h0
`define SNF_PROTO_BIT    0
`define SNF_UVDIS_BIT    1

// Message word fields
`define SNF_MSG_RST      24'h00_0000

// Slow channel formats and message lengths in frames
`define SNF_SER_NONE     2'h0
`define SNF_SER_SHORT    2'h1
`define SNF_SER_ENH12    2'h2
`define SNF_SER_ENH16    2'h3
`define SNF_FRM_SHORT    5'h10
`define SNF_FRM_ENH      5'h12
`define SNF_SER_W        36

// Fixed interval lengths in ticks
`define SNF_TICKS_0      4'h5
`define SNF_TICKS_1      4'h4
`define SNF_TICKS_2      4'h7
`define SNF_TICKS_3      4'h8

// Pause pulse policies that wait for a trigger
`define SNF_UPD_TRIG_A   3'h3
`define SNF_UPD_TRIG_B   3'h4

// Error codes in status bits 1:0
`define SNF_ERR_NONE     2'h0
`define SNF_ERR_LOWV     2'h1
`define SNF_ERR_OVERV    2'h2
`define SNF_ERR_FATAL    2'h3
`define SNF_ERR_GENERIC  2'h1

// Bus responses
`define SNF_RESP_OKAY    2'h0
`define SNF_RESP_SLVERR  2'h2

`endif

/* File: snf_sent_rx.sv */
// SENT receiver model taking frame words promptly or with random stalls
`timescale 1ns/1ps
module snf_sent_rx (
   // Clock and reset
   input  logic       sys_clk,
   input  logic       arst_n,
   // Pace: high stalls on a pseudo-random pattern
   input  logic       slow,
   // Frame stream
   input  logic [3:0] frmStatus,
   input  logic       frmValid,
   output logic       frmReady
);
   logic [1:0] serBits[$];
   logic [7:0] lfsr;
   // Ready moves only just after an edge; a word counts where valid and ready meet
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         frmReady <= 1'b0;
         lfsr     <= 8'h5A;
      end else begin
         lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         frmReady <= !slow || lfsr[0];
         if (frmValid && frmReady) serBits.push_back(frmStatus[3:2]);
      end
   end
endmodule // snf_sent_rx

/* File: snf_status_formatter.v */
// SENT nibble level, slow channel and error status formatter with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "snf_map.vh"

// Contract
// - Level bit 0: low fixed, high informs
// - Level bit 1: high fixed, low informs
// - Trigger-wait pause modes: fixed low time
// - Settings apply only in SENT protocol
// - Error in bits 1:0, serial 3:2
// - Format 00 sends bits 3:2 zero
// - Format 01: 8+4 bits, 16 frames
// - Format 10: 12+4 bits, 18 frames
// - Format 11: 16+8 bits, 18 frames
// - Serial formats carry two bits per frame
// - Style 0: none, lowV, overV, fatal
// - Style 1: any error reads 01
// - Low supply reported only if detection on
// - Fixed interval ticks 5,4,7,8 by setting
module snf_status_formatter (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        arst_n,
   // AXI4-Lite write address and data
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // Error conditions from on-chip monitors
   input  wire        lowSupply,
   input  wire        overVoltage,
   input  wire        memFault,
   // Per-frame settings toward the SENT transmitter
   output wire [3:0]  frmStatus,
   output wire [3:0]  frmFixedTicks,
   output wire        frmInfoHigh,
   output wire        frmPauseFixedLow,
   output wire        frmValid,
   input  wire        frmReady
);

   // Indexes are six bits wide; the two low address bits pick a byte
   localparam [7:0] CFG_IDX   = `SNF_CFG_IDX;
   localparam [7:0] CTRL_IDX  = `SNF_CTRL_IDX;
   localparam [7:0] MSG_IDX   = `SNF_MSG_IDX;
   localparam [7:0] STAT_IDX  = `SNF_STAT_IDX;
   localparam [7:0] CFG_ADDR  = {CFG_IDX[5:0], 2'b00};
   localparam [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
   localparam [7:0] MSG_ADDR  = {MSG_IDX[5:0], 2'b00};
   localparam [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'b00};
   localparam       WORD_W    = 10;

   // Bus slave state
   reg                   awReady_reg;
   reg                   wReady_reg;
   reg                   bValid_reg;
   reg  [1:0]            bResp_reg;
   reg                   arReady_reg;
   reg                   rValid_reg;
   reg  [1:0]            rResp_reg;
   reg  [31:0]           rData_reg;
   reg                   awHeld_reg;
   reg                   wHeld_reg;
   reg  [7:0]            awAddr_reg;
   reg  [31:0]           wData_reg;
   reg  [3:0]            wStrb_reg;

   // Software visible settings
   reg  [`SNF_CFG_W-1:0] cfg_reg;
   reg  [1:0]            ctrl_reg;
   reg  [23:0]           msg_reg;

   // Slow channel sequencer
   reg  [`SNF_SER_W-1:0] shift_reg;
   reg  [4:0]            frmIdx_reg;
   reg  [1:0]            curFmt_reg;
   reg                   needLoad_reg;
   reg  [3:0]            lastNibble_reg;

   // Decoded settings and frame word
   wire [1:0]            serFmt;
   wire                  errStyle;
   wire                  levelBit;
   wire [1:0]            fixedSel;
   wire [2:0]            pauseMode;
   wire                  sentActive;
   wire                  lowVisible;
   reg  [1:0]            errCode;
   reg  [3:0]            fixedTicks;
   reg  [`SNF_SER_W-1:0] loadVec;
   reg  [4:0]            msgFrames;
   wire                  restart;
   wire [`SNF_SER_W-1:0] serNow;
   wire [1:0]            serBits;
   wire [3:0]            statusNibble;
   wire                  pauseFixed;
   wire [WORD_W-1:0]     genWord;
   wire                  genValid;
   wire                  bufInReady;
   wire                  push;
   wire [WORD_W-1:0]     bufWord;
   wire [31:0]           wMask;
   wire                  doWrite;

   // Bus outputs come straight from their flops
   assign s_axi_awready = awReady_reg;
   assign s_axi_wready  = wReady_reg;
   assign s_axi_bvalid  = bValid_reg;
   assign s_axi_bresp   = bResp_reg;
   assign s_axi_arready = arReady_reg;
   assign s_axi_rvalid  = rValid_reg;
   assign s_axi_rresp   = rResp_reg;
   assign s_axi_rdata   = rData_reg;

   // Field decode of the settings words
   // Level, pause and tick fields are passed on for the transmitter only
   assign serFmt    = cfg_reg[`SNF_SERIAL_LSB+1:`SNF_SERIAL_LSB];
   assign errStyle  = cfg_reg[`SNF_STYLE_BIT];
   assign levelBit  = cfg_reg[`SNF_LEVEL_BIT];
   assign fixedSel  = cfg_reg[`SNF_FIXED_LSB+1:`SNF_FIXED_LSB];
   assign pauseMode = cfg_reg[`SNF_UPDATE_LSB+2:`SNF_UPDATE_LSB];
   // PWM output stops frame production altogether
   assign sentActive = ~ctrl_reg[`SNF_PROTO_BIT];
   assign lowVisible = lowSupply & ~ctrl_reg[`SNF_UVDIS_BIT];

   // Error code; the worst condition wins when several are present
   // Style 1 hides which monitor fired, only that one did
   always @* begin
      errCode = `SNF_ERR_NONE;
      if (errStyle) begin
         if (memFault || overVoltage || lowVisible) begin
            errCode = `SNF_ERR_GENERIC;
         end
      end else if (memFault) begin
         errCode = `SNF_ERR_FATAL;
      end else if (overVoltage) begin
         errCode = `SNF_ERR_OVERV;
      end else if (lowVisible) begin
         errCode = `SNF_ERR_LOWV;
      end
   end

   // Fixed interval length in ticks
   // An unknown select falls back to the standard five ticks
   always @* begin
      case (fixedSel)
         2'h0:    fixedTicks = `SNF_TICKS_0;
         2'h1:    fixedTicks = `SNF_TICKS_1;
         2'h2:    fixedTicks = `SNF_TICKS_2;
         2'h3:    fixedTicks = `SNF_TICKS_3;
         default: fixedTicks = `SNF_TICKS_0;
      endcase
   end

   // Message image, identifier then value, left aligned; tail slots send zero
   // Short messages end after 16 frames, so bits past 32 are never sent
   always @* begin
      loadVec   = {`SNF_SER_W{1'b0}};
      msgFrames = `SNF_FRM_ENH;
      case (serFmt)
         `SNF_SER_SHORT: begin
            loadVec   = {msg_reg[19:16], msg_reg[7:0], {24{1'b0}}};
            msgFrames = `SNF_FRM_SHORT;
         end
         `SNF_SER_ENH12: begin
            loadVec   = {msg_reg[19:16], msg_reg[11:0], {20{1'b0}}};
         end
         `SNF_SER_ENH16: begin
            loadVec   = {msg_reg[23:16], msg_reg[15:0], {12{1'b0}}};
         end
         default: begin
            loadVec   = {`SNF_SER_W{1'b0}};
         end
      endcase
   end

   // A new message starts after reset, after the last frame, or on a format change
   // A message word written mid-message waits for the next restart
   assign restart = needLoad_reg | (serFmt != curFmt_reg) |
                    (frmIdx_reg == msgFrames);
   assign serNow  = restart ? loadVec : shift_reg;
   // Two message bits ride in each frame, the higher one on bit 3
   assign serBits = (serFmt == `SNF_SER_NONE) ? 2'b00 :
                    serNow[`SNF_SER_W-1:`SNF_SER_W-2];
   assign statusNibble = {serBits, errCode};

   // Trigger-wait pause pulses keep a fixed low time whatever the level bit
   assign pauseFixed = (pauseMode == `SNF_UPD_TRIG_A) |
                       (pauseMode == `SNF_UPD_TRIG_B);

   // Information on high when level bit is 0, on low when it is 1
   // Inverting here lets the flag name the level that carries the value
   assign genWord  = {pauseFixed, ~levelBit, fixedTicks, statusNibble};
   assign genValid = sentActive;
   assign push     = genValid & bufInReady;

   // Sequencer advances only when a frame word is really accepted
   // Words are built up to two frames ahead, so new settings and errors
   // reach the transmitter only once the buffered words have gone
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_reg      <= {`SNF_SER_W{1'b0}};
         frmIdx_reg     <= 5'h00;
         curFmt_reg     <= `SNF_SER_NONE;
         needLoad_reg   <= 1'b1;
         lastNibble_reg <= 4'h0;
      end else if (push) begin
         shift_reg      <= {serNow[`SNF_SER_W-3:0], 2'b00};
         frmIdx_reg     <= restart ? 5'h01 : frmIdx_reg + 5'h01;
         curFmt_reg     <= serFmt;
         needLoad_reg   <= 1'b0;
         lastNibble_reg <= statusNibble;
      end
   end

   // Buffer absorbs a stall by the transmitter; its head feeds the frame outputs
   snf_frame_buf #(
      .W (WORD_W)
   ) uFrameBuf (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .inData   (genWord),
      .inValid  (genValid),
      .inReady  (bufInReady),
      .outData  (bufWord),
      .outValid (frmValid),
      .outReady (frmReady)
   );

   // Frame outputs are the head flops of the buffer, unchanged
   assign frmStatus        = bufWord[3:0];
   assign frmFixedTicks    = bufWord[7:4];
   assign frmInfoHigh      = bufWord[8];
   assign frmPauseFixedLow = bufWord[9];

   // Byte lane mask from the held strobes
   // Strobes are held with the data, as the address may come later
   assign wMask   = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
                     {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
   assign doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;

   // Write channels: address and data taken in either order, answer after both
   // Readies stay low until the answer is taken: one write at a time
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         awReady_reg <= 1'b0;
         wReady_reg  <= 1'b0;
         bValid_reg  <= 1'b0;
         bResp_reg   <= `SNF_RESP_OKAY;
         awHeld_reg  <= 1'b0;
         wHeld_reg   <= 1'b0;
         awAddr_reg  <= 8'h00;
         wData_reg   <= 32'h0000_0000;
         wStrb_reg   <= 4'h0;
         cfg_reg     <= `SNF_CFG_RST;
         ctrl_reg    <= `SNF_CTRL_RST;
         msg_reg     <= `SNF_MSG_RST;
      end else begin
         if (s_axi_awvalid && awReady_reg) begin
            awHeld_reg  <= 1'b1;
            awAddr_reg  <= s_axi_awaddr;
            awReady_reg <= 1'b0;
         end else if (!awHeld_reg && !bValid_reg) begin
            awReady_reg <= 1'b1;
         end
         if (s_axi_wvalid && wReady_reg) begin
            wHeld_reg  <= 1'b1;
            wData_reg  <= s_axi_wdata;
            wStrb_reg  <= s_axi_wstrb;
            wReady_reg <= 1'b0;
         end else if (!wHeld_reg && !bValid_reg) begin
            wReady_reg <= 1'b1;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            bValid_reg <= 1'b1;
            bResp_reg  <= `SNF_RESP_OKAY;
            // Unmapped offsets answer SLVERR and change nothing
            case (awAddr_reg & 8'hFC)
               CFG_ADDR:
                  cfg_reg  <= (cfg_reg & ~wMask[`SNF_CFG_W-1:0]) |
                              (wData_reg[`SNF_CFG_W-1:0] & wMask[`SNF_CFG_W-1:0]);
               CTRL_ADDR:
                  ctrl_reg <= (ctrl_reg & ~wMask[1:0]) | (wData_reg[1:0] & wMask[1:0]);
               MSG_ADDR:
                  msg_reg  <= (msg_reg & ~wMask[23:0]) | (wData_reg[23:0] & wMask[23:0]);
               STAT_ADDR:
                  bResp_reg <= `SNF_RESP_OKAY;  // Read-only, write ignored
               default:
                  bResp_reg <= `SNF_RESP_SLVERR;
            endcase
         end else if (bValid_reg && s_axi_bready) begin
            bValid_reg <= 1'b0;
         end
      end
   end

   // Read channel: one read at a time, data one edge after the address
   // Data are captured at the address edge; later changes are not seen
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         arReady_reg <= 1'b0;
         rValid_reg  <= 1'b0;
         rResp_reg   <= `SNF_RESP_OKAY;
         rData_reg   <= 32'h0000_0000;
      end else if (s_axi_arvalid && arReady_reg) begin
         arReady_reg <= 1'b0;
         rValid_reg  <= 1'b1;
         rResp_reg   <= `SNF_RESP_OKAY;
         rData_reg   <= 32'h0000_0000;
         case (s_axi_araddr & 8'hFC)
            CFG_ADDR:  rData_reg <= {{(32-`SNF_CFG_W){1'b0}}, cfg_reg};
            CTRL_ADDR: rData_reg <= {30'h0000_0000, ctrl_reg};
            MSG_ADDR:  rData_reg <= {8'h00, msg_reg};
            // Status is a debug snapshot of the sequencer
            STAT_ADDR: rData_reg <= {21'h00_0000, bufInReady, sentActive,
                                     frmIdx_reg, lastNibble_reg};
            default:   rResp_reg <= `SNF_RESP_SLVERR;
         endcase
      end else if (rValid_reg && s_axi_rready) begin
         rValid_reg  <= 1'b0;
      end else if (!rValid_reg) begin
         arReady_reg <= 1'b1;
      end
   end

endmodule // snf_status_formatter

/* File: snf_status_formatter_asserts.sv */
// Port-level checks of the SENT status nibble formatter
`timescale 1ns/1ps
module snf_status_formatter_asserts (
   // Clock and reset
   input logic        sys_clk,
   input logic        arst_n,
   // Register writes
   input logic [7:0]  s_axi_awaddr,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   // Error monitors
   input logic        lowSupply,
   input logic        overVoltage,
   input logic        memFault,
   // Frame stream
   input logic [3:0]  frmStatus,
   input logic [3:0]  frmFixedTicks,
   input logic        frmInfoHigh,
   input logic        frmPauseFixedLow,
   input logic        frmValid,
   input logic        frmReady
);
   logic [17:0] cfgSh;
   logic [1:0]  ctrlSh;
   logic [2:0]  errSh;
   logic [1:0]  sinceWr;
   logic [1:0]  sinceErr;
   wire         wrHit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire         hs = frmValid && frmReady;
   wire         settled = frmValid && sinceWr == 2'h3 && !ctrlSh[0];
   wire         steady = settled && sinceErr == 2'h3 &&
                         errSh == {memFault, overVoltage, lowSupply};
   wire [3:0]   ticks = cfgSh[10] ? (cfgSh[9] ? 4'h8 : 4'h7) : (cfgSh[9] ? 4'h4 : 4'h5);
   // Shadow settings; count words taken since a change, as two may be buffered ahead
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfgSh    <= '0;
         ctrlSh   <= '0;
         errSh    <= '0;
         sinceWr  <= '0;
         sinceErr <= '0;
      end else begin
         errSh <= {memFault, overVoltage, lowSupply};
         if (wrHit && s_axi_awaddr[7:2] == 6'h1E) cfgSh <= s_axi_wdata[17:0];
         if (wrHit && s_axi_awaddr[7:2] == 6'h20) ctrlSh <= s_axi_wdata[1:0];
         if (wrHit) sinceWr <= 2'h0;
         else if (hs && sinceWr != 2'h3) sinceWr <= sinceWr + 2'h1;
         if (errSh != {memFault, overVoltage, lowSupply}) sinceErr <= 2'h0;
         else if (hs && sinceErr != 2'h3) sinceErr <= sinceErr + 2'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   AST_LOW_FIXED: assert property (settled && !cfgSh[8] |-> frmInfoHigh)
      else $error("level bit 0 but low interval not fixed");
   AST_HIGH_FIXED: assert property (settled && cfgSh[8] |-> !frmInfoHigh)
      else $error("level bit 1 but high interval not fixed");
   AST_PAUSE_LOW: assert property (settled |-> frmPauseFixedLow == (cfgSh[7:5] inside {3'h3, 3'h4}))
      else $error("pause fixed low flag wrong");
   AST_TICKS: assert property (settled |-> frmFixedTicks == ticks)
      else $error("fixed interval ticks wrong");
   AST_FMT_NONE: assert property (settled && cfgSh[1:0] == 2'h0 |-> frmStatus[3:2] == 2'h0)
      else $error("serial bits not zero without slow channel");
   AST_NO_ERR: assert property (steady && !(lowSupply || overVoltage || memFault) |-> frmStatus[1:0] == 2'h0)
      else $error("error code without error");
   AST_STYLE0: assert property (steady && !cfgSh[2] && (overVoltage || memFault)
      |-> frmStatus[1:0] == (memFault ? 2'h3 : 2'h2))
      else $error("detailed error code wrong");
   AST_STYLE1: assert property (steady && cfgSh[2] && (overVoltage || memFault) |-> frmStatus[1:0] == 2'h1)
      else $error("generic error code wrong");
   AST_LOW_SUPPLY: assert property (steady && lowSupply && !overVoltage && !memFault
      |-> frmStatus[1:0] == (ctrlSh[1] ? 2'h0 : 2'h1))
      else $error("low supply code wrong");
   AST_PWM_STOP: assert property (ctrlSh[0] && sinceWr == 2'h3 |=> !frmValid)
      else $error("words go on in PWM mode");
   // Main scenarios reached
   cover property (hs && frmStatus[1:0] == 2'h3);
   cover property (settled && cfgSh[8] && frmPauseFixedLow);
   cover property (settled && cfgSh[1:0] == 2'h3 && frmStatus[3:2] != 2'h0);
endmodule // snf_status_formatter_asserts

bind snf_status_formatter snf_status_formatter_asserts chk (.sys_clk, .arst_n, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .lowSupply,
   .overVoltage, .memFault, .frmStatus, .frmFixedTicks, .frmInfoHigh, .frmPauseFixedLow,
   .frmValid, .frmReady);

/* File: snf_testbench.sv */
// Self-checking bench of the SENT status nibble formatter
`timescale 1ns/1ps
`include "snf_map.vh"
module testbench;
   localparam logic [7:0] ACFG = `SNF_CFG_IDX << 2;
   localparam logic [7:0] ACTRL = `SNF_CTRL_IDX << 2;
   localparam logic [7:0] AMSG = `SNF_MSG_IDX << 2;
   logic        sys_clk, arst_n, slow, lowSupply, overVoltage, memFault;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, cfg, msg, errRnd;
   logic [3:0]  s_axi_wstrb, frmStatus, frmFixedTicks;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        frmInfoHigh, frmPauseFixedLow, frmValid, frmReady, ok;
   logic [35:0] pat;
   logic [34:0] expQ[$];
   logic [34:0] expNow;
   logic [5:0]  errTick;
   int          failures, nChecks, len, base;

   snf_status_formatter DUT (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .lowSupply, .overVoltage, .memFault, .frmStatus,
      .frmFixedTicks, .frmInfoHigh, .frmPauseFixedLow, .frmValid, .frmReady);
   snf_sent_rx rx (.sys_clk, .arst_n, .slow, .frmStatus, .frmValid, .frmReady);

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      nChecks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d failures %0d", nChecks, failures);
      if (failures == 0 && nChecks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Waits edge by edge for a handshake signal; a hang ends the run
   task automatic waitEdge(ref logic sig);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (sig !== 1'b1 && n < 200);
      if (n >= 200) begin
         failures++;
         conclude();
      end
   endtask

   task automatic axiWrite(logic [7:0] addr, logic [31:0] data, logic [1:0] resp);
      expQ.push_back({1'b0, resp, 32'h0000_0000});
      s_axi_awaddr  <= addr;
      s_axi_wdata   <= data;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      fork
         begin
            waitEdge(s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            waitEdge(s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      waitEdge(s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic axiRead(logic [7:0] addr, logic [31:0] data, logic [1:0] resp);
      expQ.push_back({1'b1, resp, data});
      s_axi_araddr  <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      waitEdge(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      waitEdge(s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Collects n fresh frames from the receiver, bounded
   task automatic waitFrames(int n);
      int k;
      rx.serBits.delete();
      for (k = 0; k < 3000 && rx.serBits.size() < n; k++) @(posedge sys_clk);
      if (k >= 3000) begin
         failures++;
         conclude();
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Every answer taken retires the oldest expectation
   always @(posedge sys_clk) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         expNow = expQ.pop_front();
         if (expNow[34]) check("rdata", expNow[31:0], s_axi_rdata);
         check("resp", {30'h0, expNow[33:32]}, {30'h0, expNow[34] ? s_axi_rresp : s_axi_bresp});
      end
   end

   // Error monitors wander slowly so each pattern lasts many frames
   always @(posedge sys_clk) begin
      errTick <= errTick + 6'h01;
      if (arst_n && errTick == 6'h00) begin
         errRnd = rnd();
         lowSupply   <= errRnd[0] & errRnd[3];
         overVoltage <= errRnd[1] & errRnd[4];
         memFault    <= errRnd[2] & errRnd[5];
      end
   end

   initial begin
      seed = 32'h0000_08A8;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, failures, nChecks, errTick} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {lowSupply, overVoltage, memFault, slow, arst_n} = '0;
      s_axi_wstrb = 4'hF;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      // Reset values, unmapped and read-only places
      axiRead(ACFG, 32'h0000_0000, `SNF_RESP_OKAY);
      axiRead(ACTRL, 32'h0000_0000, `SNF_RESP_OKAY);
      axiRead(8'h7C, 32'h0000_0000, `SNF_RESP_SLVERR);
      axiWrite(8'h7C, 32'hFFFF_FFFF, `SNF_RESP_SLVERR);
      axiWrite(`SNF_STAT_IDX << 2, 32'hFFFF_FFFF, `SNF_RESP_OKAY);
      // Sweep level, fixed interval and pause policy with random remaining fields
      for (int i = 0; i < 64; i++) begin
         cfg = rnd();
         cfg[10:5] = {i[1:0], i[5], i[4:2]};
         slow <= i[0];
         axiWrite(ACFG, cfg, `SNF_RESP_OKAY);
         axiWrite(ACTRL, {30'h0, cfg[31], 1'b0}, `SNF_RESP_OKAY);
         axiRead(ACFG, cfg & 32'h0003_FFFF, `SNF_RESP_OKAY);
         waitFrames(12);
      end
      // Each slow channel format, level bit kept at 0
      for (int f = 1; f < 4; f++) begin
         msg = rnd() & 32'h00FF_FFFF;
         len = (f == 1) ? 16 : 18;
         pat = (f == 1) ? {msg[19:16], msg[7:0], 24'h00_0000} :
               (f == 2) ? {msg[19:16], msg[11:0], 20'h0_0000} : {msg[23:16], msg[15:0], 12'h000};
         axiWrite(AMSG, msg, `SNF_RESP_OKAY);
         axiWrite(ACFG, f, `SNF_RESP_OKAY);
         // The first len frames may still finish an older message
         waitFrames(3 * len + 4);
         ok = 1'b0;
         for (int k = 0; k < len; k++) begin
            base = 1;
            for (int j = 0; j < 2 * len; j++)
               if (rx.serBits[len + 4 + j] !== pat[35 - 2 * ((j + k) % len) -: 2]) base = 0;
            if (base == 1) ok = 1'b1;
         end
         check("serial message", 32'h1, {31'h0, ok});
      end
      // PWM selected: buffered words drain, then the stream stays quiet
      axiWrite(ACTRL, 32'h0000_0001, `SNF_RESP_OKAY);
      for (int k = 0; k < 100 && frmValid; k++) @(posedge sys_clk);
      len = rx.serBits.size();
      repeat (40) @(posedge sys_clk);
      check("pwm frames", len, rx.serBits.size());
      axiWrite(ACTRL, 32'h0000_0000, `SNF_RESP_OKAY);
      waitFrames(4);
      conclude();
   end
endmodule // testbench
